// [logic/dcm_top.sv]
// Dual clock mode control: oscillator enables, clock selection, instruction
// tick, operating modes, wakeup and start-up hold, with one control register.
// Assumes oscillator levels arrive asynchronously on pins and are sampled on clk.
`timescale 1ns/1ps
module dcm_top #(
    parameter dcm_pkg::dcm_fast_type_t FAST_TYPE = dcm_pkg::FT_INT_RC,
    parameter int FAST_DIV = dcm_pkg::FAST_DIV_DEF,
    parameter bit WDT_EN = 1'b1,
    parameter bit NOISE_FILTER = 1'b0,
    parameter int WAKE_W = 8,
    parameter int WAKE_CLKS = dcm_pkg::WAKE_FAST_CLKS,
    parameter int RC_START_CLKS = dcm_pkg::STARTUP_RC_CLKS,
    parameter int XTAL_START_CLKS = dcm_pkg::STARTUP_XTAL_CLKS,
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire dcm_pkg::dcm_bus_req_t bus_req,
    output logic [7:0] rd_data,
    // Oscillator levels
    input wire logic internal_fast_rc,
    input wire logic internal_slow_rc,
    input wire logic osc_input_pin,
    // Oscillator enables and pin control
    output dcm_pkg::dcm_osc_en_t osc_en,
    output logic osc_output_pin_o,
    output logic osc_output_pin_oe,
    output logic input_pin_is_gpio,
    output logic output_pin_is_gpio,
    // Wakeup sources
    input wire logic [WAKE_W-1:0] wake_port,
    input wire logic wake_timer,
    // Core timing
    output logic instr_tick,
    output logic watchdog_tick,
    output logic cpu_hold
);
    import dcm_pkg::*;

    // ----------------------------------------
    // Local constants
    // ----------------------------------------
    localparam int NS = SYNC_WAKE + WAKE_W;
    localparam int START_CLKS = dcm_is_crystal(FAST_TYPE) ? XTAL_START_CLKS : RC_START_CLKS;
    localparam logic [CNT_W-1:0] START_LAST = CNT_W'(START_CLKS - 1);
    localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CLKS - 1);
    localparam bit SLOW_STOPS_IN_GREEN = (FAST_TYPE == FT_32K) && !WDT_EN;

    typedef enum logic [2:0] {
        ST_BOOT = 3'b001,
        ST_RUN = 3'b010,
        ST_WAKE = 3'b100
    } dcm_state_t;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    dcm_state_t state_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic stop_reg;
    logic low_sel_reg;
    dcm_mode_t mode_reg;
    logic [NS-1:0] raw;
    logic [NS-1:0] sy1_reg;
    logic [NS-1:0] sy2_reg;
    logic [NS-1:0] sy3_reg;
    logic [NS-1:0] sy4_reg;
    logic [NS-1:0] filt_reg;
    logic [NS-1:0] filt_d_reg;
    logic [NS-1:0] agree;
    logic fast_src;
    logic fast_edge;
    logic slow_edge;
    logic wake_change;
    logic reg_hit_wr;
    logic reg_hit_rd;
    logic count_done;
    logic green_wake;
    logic sleep_wake;
    logic fast_on;
    logic slow_on;
    logic cpu_run;
    logic fast_pulse;
    logic slow_pulse;
    logic [7:0] reg_image;

    // ----------------------------------------
    // Input sampling and noise filter
    // ----------------------------------------
    // Fast clock comes from the on-chip RC or from the oscillator input pin
    assign fast_src = (FAST_TYPE == FT_INT_RC) ? internal_fast_rc : osc_input_pin;
    assign raw = {wake_port, internal_slow_rc, fast_src};

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sy1_reg <= '0;
            sy2_reg <= '0;
            sy3_reg <= '0;
            sy4_reg <= '0;
        end else begin
            sy1_reg <= raw;
            sy2_reg <= sy1_reg;
            sy3_reg <= sy2_reg;
            sy4_reg <= sy3_reg;
        end
    end

    // The filter demands one more agreeing sample on the clock paths only;
    // it costs a cycle of latency but rejects glitches of up to two samples.
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_agree
            if (NOISE_FILTER && gi < SYNC_WAKE) begin : g_filt
                assign agree[gi] = (sy2_reg[gi] == sy3_reg[gi]) &&
                    (sy3_reg[gi] == sy4_reg[gi]);
            end else begin : g_plain
                assign agree[gi] = (sy2_reg[gi] == sy3_reg[gi]);
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            filt_reg <= '0;
            filt_d_reg <= '0;
        end else begin
            filt_reg <= (agree & sy3_reg) | (~agree & filt_reg);
            filt_d_reg <= filt_reg;
        end
    end

    assign fast_edge = filt_reg[SYNC_FAST] && !filt_d_reg[SYNC_FAST] && fast_on;
    assign slow_edge = filt_reg[SYNC_SLOW] && !filt_d_reg[SYNC_SLOW] && slow_on;
    assign wake_change = |(filt_reg[NS-1:SYNC_WAKE] ^ filt_d_reg[NS-1:SYNC_WAKE]);

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    assign reg_hit_wr = bus_req.wr && (bus_req.addr == MODE_CTRL_ADDR);
    assign reg_hit_rd = bus_req.rd && (bus_req.addr == MODE_CTRL_ADDR);
    assign green_wake = (state_reg == ST_RUN) && (mode_reg == MODE_GREEN) &&
        (wake_change || wake_timer);
    assign sleep_wake = (state_reg == ST_RUN) && (mode_reg == MODE_SLEEP) && wake_change;
    assign count_done = fast_edge && (cnt_reg == WAKE_LAST);

    // Hardware wakeups win over a software write in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stop_reg <= MODE_CTRL_RESET[STOP_BIT];
            low_sel_reg <= MODE_CTRL_RESET[LOW_SEL_BIT];
            mode_reg <= dcm_mode_t'(MODE_CTRL_RESET[MODE_MSB:MODE_LSB]);
        end else if (state_reg == ST_WAKE && count_done) begin
            // Sleep always returns to normal mode on a running fast clock
            mode_reg <= MODE_NORMAL;
            low_sel_reg <= 1'b0;
            stop_reg <= 1'b0;
        end else if (green_wake) begin
            // Low clock select is kept, so the previous mode resumes
            mode_reg <= MODE_NORMAL;
        end else if (reg_hit_wr) begin
            stop_reg <= bus_req.wdata[STOP_BIT];
            low_sel_reg <= bus_req.wdata[LOW_SEL_BIT];
            // The reserved code is refused and leaves the mode unchanged
            if (bus_req.wdata[MODE_MSB:MODE_LSB] != MODE_RSVD) begin
                mode_reg <= dcm_mode_t'(bus_req.wdata[MODE_MSB:MODE_LSB]);
            end
        end
    end

    always_comb begin
        reg_image = '0;
        reg_image[STOP_BIT] = stop_reg;
        reg_image[LOW_SEL_BIT] = low_sel_reg;
        reg_image[MODE_MSB:MODE_LSB] = mode_reg;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_data <= '0;
        end else begin
            rd_data <= reg_hit_rd ? reg_image : '0;
        end
    end

    // ----------------------------------------
    // Start-up and wakeup sequencer
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= ST_BOOT;
            cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                ST_BOOT: begin
                    // Hold length depends on the oscillator's start-up time
                    if (fast_edge) begin
                        cnt_reg <= cnt_reg + CNT_W'(1);
                        if (cnt_reg == START_LAST) begin
                            state_reg <= ST_RUN;
                            cnt_reg <= '0;
                        end
                    end
                end
                ST_RUN: begin
                    if (sleep_wake) begin
                        state_reg <= ST_WAKE;
                        cnt_reg <= '0;
                    end
                end
                ST_WAKE: begin
                    if (fast_edge) begin
                        cnt_reg <= cnt_reg + CNT_W'(1);
                        if (count_done) begin
                            state_reg <= ST_RUN;
                            cnt_reg <= '0;
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Oscillator enables and pins
    // ----------------------------------------
    // The fast oscillator must run through start-up and the wakeup wait
    assign fast_on = (state_reg != ST_RUN) ||
        (!stop_reg && mode_reg != MODE_SLEEP);
    // No register bit reaches the slow RC: only the mode and the options stop it
    assign slow_on = (state_reg != ST_RUN) ||
        !((mode_reg == MODE_SLEEP) ||
          (mode_reg == MODE_GREEN && SLOW_STOPS_IN_GREEN));

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            osc_en <= '0;
        end else begin
            osc_en.fast_rc_en <= fast_on && (FAST_TYPE == FT_INT_RC);
            osc_en.ext_osc_en <= fast_on && (FAST_TYPE != FT_INT_RC);
            osc_en.slow_rc_en <= slow_on;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            osc_output_pin_o <= 1'b0;
            osc_output_pin_oe <= 1'b0;
            input_pin_is_gpio <= 1'b0;
            output_pin_is_gpio <= 1'b0;
        end else begin
            // Crystal feedback drive is the inverse of the sampled input
            osc_output_pin_o <= !filt_reg[SYNC_FAST];
            osc_output_pin_oe <= dcm_is_crystal(FAST_TYPE) && fast_on;
            input_pin_is_gpio <= (FAST_TYPE == FT_INT_RC);
            output_pin_is_gpio <= dcm_out_pin_free(FAST_TYPE);
        end
    end

    // ----------------------------------------
    // Instruction and watchdog ticks
    // ----------------------------------------
    dcm_div #(.DIV(FAST_DIV)) u_fast_div (
        .clk(clk),
        .rst_b(rst_b),
        .tick(fast_edge),
        .clear(state_reg != ST_RUN),
        .pulse(fast_pulse)
    );

    dcm_div #(.DIV(SLOW_DIV)) u_slow_div (
        .clk(clk),
        .rst_b(rst_b),
        .tick(slow_edge),
        .clear(state_reg != ST_RUN),
        .pulse(slow_pulse)
    );

    // Green and sleep halt the instruction stream
    assign cpu_run = (state_reg == ST_RUN) && (mode_reg == MODE_NORMAL);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            instr_tick <= 1'b0;
            watchdog_tick <= 1'b0;
            cpu_hold <= 1'b1;
        end else begin
            instr_tick <= cpu_run && (low_sel_reg ? slow_pulse : fast_pulse);
            watchdog_tick <= slow_edge;
            cpu_hold <= (state_reg != ST_RUN);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    mode_code_legal_a: assert property (@(posedge clk) disable iff (!rst_b)
        mode_reg != MODE_RSVD)
        else $error("operating mode holds the reserved code");

    sleep_stops_osc_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == ST_RUN && mode_reg == MODE_SLEEP && !sleep_wake)
        |=> !osc_en.fast_rc_en && !osc_en.ext_osc_en && !osc_en.slow_rc_en)
        else $error("an oscillator runs in sleep");

    stop_bit_fast_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == ST_RUN && stop_reg && mode_reg == MODE_NORMAL)
        |=> !osc_en.fast_rc_en && !osc_en.ext_osc_en && osc_en.slow_rc_en)
        else $error("stop bit did not halt only the fast oscillator");

    slow_rc_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(osc_en.slow_rc_en) |-> $past(mode_reg) == MODE_SLEEP ||
            ($past(mode_reg) == MODE_GREEN && SLOW_STOPS_IN_GREEN))
        else $error("slow RC stopped outside its stop conditions");

    wake_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == ST_WAKE) ##1 (state_reg == ST_RUN)
        |-> $past(cnt_reg) == WAKE_LAST && mode_reg == MODE_NORMAL)
        else $error("sleep wakeup left before the stabilisation count");

    green_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
        green_wake |=> state_reg == ST_RUN && mode_reg == MODE_NORMAL &&
            low_sel_reg == $past(low_sel_reg))
        else $error("green wakeup was delayed or lost the clock mode");

    sleep_timer_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == ST_RUN && mode_reg == MODE_SLEEP && wake_timer && !wake_change)
        |=> mode_reg == MODE_SLEEP && state_reg == ST_RUN)
        else $error("timer woke the device from sleep");

    slow_instr_a: assert property (@(posedge clk) disable iff (!rst_b)
        (instr_tick && $past(low_sel_reg)) |-> $past(slow_pulse) && !$past(fast_pulse, 1) ||
            $past(slow_pulse))
        else $error("slow mode instruction tick not from the slow divider");

    unused_bits_a: assert property (@(posedge clk) disable iff (!rst_b)
        rd_data[7:MODE_MSB+1] == '0 && rd_data[0] == 1'b0)
        else $error("unused control bits read as one");

    reg_read_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_hit_rd ##1 !$past(reg_hit_wr) |-> rd_data[LOW_SEL_BIT] == $past(low_sel_reg))
        else $error("read data does not show the low clock select");

    pin_release_a: assert property (@(posedge clk) disable iff (!rst_b)
        osc_output_pin_oe |-> !output_pin_is_gpio && !input_pin_is_gpio)
        else $error("oscillator output drives a released pin");

    boot_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == ST_BOOT) |=> cpu_hold && !instr_tick)
        else $error("core released during start-up hold");

endmodule

// [logic/dcm_pkg.sv]
// Constants, types and decoders shared by the dual clock mode control block.
// Assumes a single 10 MHz system clock and a synchronous, active-low reset.
//
// Behaviour
// - Fast clock from external or internal RC.
// - Normal mode instruction clock is fast over N.
// - Slow mode instruction clock is slow over four.
// - Stop bit halts fast oscillator, slow keeps running.
// - Low clock select picks slow clock.
// - Mode field: normal, sleep, green, reserved.
// - Sleep stops both oscillators.
// - Slow RC stops: sleep, or green-32K-no-watchdog.
// - No separate control stops the slow RC.
// - Slow RC clocks watchdog and slow mode.
// - Build option selects fast clock type.
// - Internal fast RC frees both oscillator pins.
// - External RC or clock frees output pin.
// - Reset period follows oscillator start-up time.
// - Build option enables clock noise filter.
// - Sleep wakeup waits 2048 fast clocks.
// - Green wakeup has no stabilisation delay.
// - Sleep wakes on port; green on port/timer.
package dcm_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] MODE_CTRL_ADDR = 8'hca;
    localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
    localparam int STOP_BIT = 1;
    localparam int LOW_SEL_BIT = 2;
    localparam int MODE_LSB = 3;
    localparam int MODE_MSB = 4;

    // ----------------------------------------
    // Timing and build-time defaults
    // ----------------------------------------
    localparam int WAKE_FAST_CLKS = 2048;
    localparam int SLOW_DIV = 4;
    localparam int FAST_DIV_DEF = 4;
    localparam int STARTUP_RC_CLKS = 64;
    localparam int STARTUP_XTAL_CLKS = 2048;
    localparam int SYNC_FAST = 0;
    localparam int SYNC_SLOW = 1;
    localparam int SYNC_WAKE = 2;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_GREEN = 2'b10,
        MODE_RSVD = 2'b11
    } dcm_mode_t;

    typedef enum logic [2:0] {
        FT_INT_RC = 3'h0,
        FT_EXT_RC = 3'h1,
        FT_32K = 3'h2,
        FT_12M = 3'h3,
        FT_4M = 3'h4
    } dcm_fast_type_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dcm_bus_req_t;

    typedef struct packed {
        logic fast_rc_en;
        logic ext_osc_en;
        logic slow_rc_en;
    } dcm_osc_en_t;

    // ----------------------------------------
    // Decoders
    // ----------------------------------------
    function automatic logic dcm_is_crystal(input dcm_fast_type_t t);
        return (t == FT_32K) || (t == FT_12M) || (t == FT_4M);
    endfunction

    function automatic logic dcm_out_pin_free(input dcm_fast_type_t t);
        return (t == FT_INT_RC) || (t == FT_EXT_RC);
    endfunction

endpackage

// [logic/dcm_div.sv]
// Tick divider: one output pulse for every DIV input ticks.
// Assumes tick is a one-cycle pulse on clk.
`timescale 1ns/1ps
module dcm_div #(
    parameter int DIV = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Ticks
    input wire logic tick,
    input wire logic clear,
    output logic pulse
);
    import dcm_pkg::*;

    localparam int CW = $clog2(DIV) + 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_reg;

    always_ff @(posedge clk) begin
        if (!rst_b || clear) begin
            cnt_reg <= '0;
            pulse <= 1'b0;
        end else begin
            pulse <= tick && (cnt_reg == LAST);
            if (tick) begin
                cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + CW'(1);
            end
        end
    end

    div_count_a: assert property (@(posedge clk) disable iff (!rst_b)
        pulse |-> $past(tick) && $past(cnt_reg) == LAST)
        else $error("divider pulsed before its terminal count");

endmodule

// [bench/dcm_osc_model.sv]
// Oscillator sources facing the clock control block: the two on-chip RC
// oscillators and the oscillator input pin.
// Assumes the run enables arrive registered on clk; periods are whole clk cycles.
`timescale 1ns/1ps
module dcm_osc_model #(
    parameter int FAST_HALF = 4,
    parameter int SLOW_HALF = 16
) (
    // Clock
    input wire logic clk,
    // Run enables
    input wire dcm_pkg::dcm_osc_en_t osc_en,
    // Oscillator levels
    output logic fast_rc,
    output logic slow_rc,
    output logic ext_in
);
    import dcm_pkg::*;

    // ----------------------------------------
    // Fast sources
    // ----------------------------------------
    int fast_cnt = 0;
    int slow_cnt = 0;
    initial fast_rc = 1'b0;
    initial slow_rc = 1'b0;
    initial ext_in = 1'b0;

    // A stopped oscillator freezes at its last level, as a real one would
    always @(posedge clk) begin
        if (osc_en.fast_rc_en || osc_en.ext_osc_en) begin
            if (fast_cnt == FAST_HALF - 1) begin
                fast_cnt <= 0;
                fast_rc <= osc_en.fast_rc_en ? ~fast_rc : fast_rc;
                ext_in <= osc_en.ext_osc_en ? ~ext_in : ext_in;
            end else begin
                fast_cnt <= fast_cnt + 1;
            end
        end
    end

    // ----------------------------------------
    // Slow source
    // ----------------------------------------
    always @(posedge clk) begin
        if (osc_en.slow_rc_en) begin
            if (slow_cnt == SLOW_HALF - 1) begin
                slow_cnt <= 0;
                slow_rc <= ~slow_rc;
            end else begin
                slow_cnt <= slow_cnt + 1;
            end
        end
    end
endmodule

// [bench/dual_clock_mode_control_tb.sv]
// Self-checking bench for the dual clock mode control block.
// Assumes the oscillator model drives the clock levels; the bench owns the
// register port and the wake sources.
`timescale 1ns/1ps
module dual_clock_mode_control_tb;
    import dcm_pkg::*;

    // ----------------------------------------
    // Settings and signals
    // ----------------------------------------
    localparam int FDIV = 4;
    localparam int FHALF = 4;
    localparam int SHALF = 16;
    localparam int WAKE = 8;
    localparam int RC_START = 4;
    localparam int XTAL_START = 16;
    localparam int NORM_GAP = FDIV * 2 * FHALF;
    localparam int SLOW_GAP = 4 * 2 * SHALF;
    localparam int WD_GAP = 2 * SHALF;
    localparam dcm_bus_req_t IDLE = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};

    logic clk = 1'b0;
    logic rst_b;
    dcm_bus_req_t bus_req;
    logic [7:0] rd_data;
    logic fast_rc, slow_rc, ext_in;
    dcm_osc_en_t osc_en;
    logic out_o, out_oe, in_gpio, out_gpio;
    logic [7:0] wake_port;
    logic wake_timer;
    logic instr_tick, watchdog_tick, cpu_hold;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    int n;

    always #50 clk = ~clk;

    dcm_top #(.FAST_TYPE(FT_INT_RC), .FAST_DIV(FDIV), .NOISE_FILTER(1'b0),
        .WAKE_CLKS(WAKE), .RC_START_CLKS(RC_START), .XTAL_START_CLKS(XTAL_START)
    ) i_dcm_top (
        .clk(clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
        .internal_fast_rc(fast_rc), .internal_slow_rc(slow_rc), .osc_input_pin(ext_in),
        .osc_en(osc_en), .osc_output_pin_o(out_o), .osc_output_pin_oe(out_oe),
        .input_pin_is_gpio(in_gpio), .output_pin_is_gpio(out_gpio),
        .wake_port(wake_port), .wake_timer(wake_timer),
        .instr_tick(instr_tick), .watchdog_tick(watchdog_tick), .cpu_hold(cpu_hold)
    );

    dcm_osc_model #(.FAST_HALF(FHALF), .SLOW_HALF(SHALF)) i_dcm_osc_model (
        .clk(clk), .osc_en(osc_en), .fast_rc(fast_rc), .slow_rc(slow_rc), .ext_in(ext_in)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_count(input int got, input int exp);
        checks++;
        if (got != exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req <= IDLE;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= IDLE;
        #1;
        check_byte(rd_data, exp);
    endtask

    // Cycles until the next instruction (or watchdog) tick; 1000 means none
    task automatic wait_tick(input bit wd, output int cnt);
        cnt = 0;
        do begin
            @(posedge clk);
            #1;
            cnt++;
        end while ((wd ? watchdog_tick : instr_tick) !== 1'b1 && cnt < 1000);
    endtask

    // Length of the next hold period in cycles
    task automatic hold_len(output int cnt);
        int k;
        k = 0;
        cnt = 0;
        while (cpu_hold !== 1'b1 && k < 100) begin
            @(posedge clk);
            #1;
            k++;
        end
        while (cpu_hold === 1'b1 && cnt < 1000) begin
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask

    task automatic pulse_timer();
        @(posedge clk);
        wake_timer <= 1'b1;
        @(posedge clk);
        wake_timer <= 1'b0;
    endtask

    // ----------------------------------------
    // Timeout
    // ----------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            n_errors++;
            results();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_b = 1'b0;
        bus_req = IDLE;
        wake_port = 8'h00;
        wake_timer = 1'b0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        check_byte({7'h0, cpu_hold}, 8'h01);
        hold_len(n);
        check_count(int'(n >= (RC_START - 1) * 2 * FHALF), 1);
        check_byte({7'h0, cpu_hold}, 8'h00);
        check_byte({6'h0, in_gpio, out_gpio}, 8'h03);
        check_byte({7'h0, out_oe}, 8'h00);
        rd_reg(MODE_CTRL_ADDR, MODE_CTRL_RESET);
        wait_tick(1'b0, n);
        wait_tick(1'b0, n);
        check_count(n, NORM_GAP);
        wait_tick(1'b1, n);
        wait_tick(1'b1, n);
        check_count(n, WD_GAP);
        // Reserved mode code and unused bits must not stick
        wr_reg(MODE_CTRL_ADDR, 8'hff);
        rd_reg(MODE_CTRL_ADDR, 8'h06);
        rd_reg(8'hc9, 8'h00);
        check_byte({5'h0, osc_en}, 8'h01);
        wait_tick(1'b0, n);
        wait_tick(1'b0, n);
        check_count(n, SLOW_GAP);
        // Green from slow mode, fast oscillator back on
        wr_reg(MODE_CTRL_ADDR, 8'h14);
        wait_tick(1'b0, n);
        check_count(n, 1000);
        check_byte({7'h0, osc_en.slow_rc_en}, 8'h01);
        pulse_timer();
        rd_reg(MODE_CTRL_ADDR, 8'h04);
        check_byte({7'h0, cpu_hold}, 8'h00);
        // Sleep: timer must not wake it, a port change must
        wr_reg(MODE_CTRL_ADDR, 8'h08);
        repeat (4) @(posedge clk);
        #1;
        check_byte({5'h0, osc_en}, 8'h00);
        pulse_timer();
        rd_reg(MODE_CTRL_ADDR, 8'h08);
        // Feedback drive settles to the inverse of the frozen fast level
        check_byte({7'h0, out_o}, {7'h0, ~fast_rc});
        @(posedge clk);
        wake_port <= 8'h01;
        hold_len(n);
        check_count(int'(n >= (2 * WAKE - 1) * FHALF), 1);
        rd_reg(MODE_CTRL_ADDR, 8'h00);
        wait_tick(1'b0, n);
        wait_tick(1'b0, n);
        check_count(n, NORM_GAP);
        // Green left by a port change returns to normal mode at once
        wr_reg(MODE_CTRL_ADDR, 8'h10);
        @(posedge clk);
        wake_port <= 8'h03;
        repeat (8) @(posedge clk);
        rd_reg(MODE_CTRL_ADDR, 8'h00);
        check_byte({7'h0, cpu_hold}, 8'h00);
        results();
    end
endmodule
